// >>> design/nvram_device.sv
// Device end: serial command decoder, 16x16 RAM with shadow nonvolatile copy.
// Assumes link pins are synchronous to clk and shift_clock is slow versus clk.
//
// Functional notes
// - Instruction: start one, four address, three opcode
// - Opcode 000 clears write permit
// - Opcode 001 saves RAM to nonvolatile
// - Opcode 011 writes following word to RAM
// - Opcode 100 sets write permit
// - Opcode 101 reloads nonvolatile into RAM
// - Opcode 11x reads addressed RAM word
// - Input bits sampled on rising shift clock
// - Output undriven except while shifting read data
// - Host holds chip enable through transfer
// - Write followed by sixteen data bits
// - Read shifts out sixteen data bits
// - First bit after eighth falling edge
// - Eighth bit of read ignored
// - Early chip enable drop aborts, clears shifter
// - Host gives exactly sixteen data clocks
// - Shift state held while clock stopped
// - Sixteen words of sixteen bits
// - Save and reload also from pins
// - Permit cleared at reset, disable, save
// - Write and save need prior reload
// - Low reload pin reloads, low save pin saves
// - Save in progress ignores everything else
`timescale 1ns/1ps
module nvram_device #(
    parameter int SAVE_CYCLES = nvram_pkg::SAVE_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Link
    nvram_link_if.dev link,
    // Status
    output logic busy,
    output logic write_permit,
    output logic reloaded
);
    import nvram_pkg::*;

    // A save must last at least one clock
    if (SAVE_CYCLES < 1) begin : g_bad_save_cycles
        $error("SAVE_CYCLES must be at least 1");
    end

    typedef enum logic [1:0] {S_INSTR, S_WDATA, S_RDATA, S_SAVE} dstate_t;

    // Shift a word left by one, taking in a new low bit
    function automatic logic [WORD_W-1:0] shift_word(input logic [WORD_W-1:0] word, input logic bit_in);
        return {word[WORD_W-2:0], bit_in};
    endfunction : shift_word

    dstate_t state_ff;
    logic [WORD_W-1:0] ram_ff [DEPTH];
    logic [WORD_W-1:0] nv_ff [DEPTH];
    logic [INSTR_W-1:0] sh_ff;
    logic [3:0] cnt_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [WORD_W-1:0] data_ff;
    logic sclk_ff;
    logic permit_ff;
    logic reloaded_ff;
    logic oe_ff;
    logic out_ff;
    logic save_pin_ff;
    logic reload_pin_ff;
    logic [31:0] save_cnt_ff;

    wire sclk_rise = link.shift_clock & ~sclk_ff;
    wire sclk_fall = ~link.shift_clock & sclk_ff;
    wire [INSTR_W-1:0] shifted = {sh_ff[INSTR_W-2:0], link.serial_in};
    wire started = sh_ff[INSTR_W-1];
    wire instr_done = sclk_rise && sh_ff[INSTR_W-2];
    wire [ADDR_W-1:0] op_addr = shifted[OP_W+ADDR_W-1:OP_W];
    wire [OP_W-1:0] opcode = shifted[OP_W-1:0];
    wire is_read = opcode[2:1] == OP_READ_HI;
    wire may_modify = permit_ff && reloaded_ff;
    wire save_pin_fall = ~link.save_n & save_pin_ff;
    wire reload_pin_fall = ~link.reload_n & reload_pin_ff;
    // Hardware reload is held off while an instruction is being shifted in
    wire idle_instr = state_ff == S_INSTR && !started && sh_ff == '0;
    wire sw_save = state_ff == S_INSTR && link.chip_en && instr_done && opcode == OP_SAVE;
    wire sw_reload = state_ff == S_INSTR && link.chip_en && instr_done && opcode == OP_RELOAD;
    // Saves need both latches, reloads need neither
    wire do_save = (sw_save || (save_pin_fall && state_ff != S_SAVE)) && may_modify;
    wire do_reload = state_ff != S_SAVE && (sw_reload || (reload_pin_fall && idle_instr));
    wire save_done = state_ff == S_SAVE && save_cnt_ff == 32'(SAVE_CYCLES - 1);
    wire wr_last = state_ff == S_WDATA && sclk_rise && cnt_ff == 4'hf;

    assign link.serial_out_o = out_ff;
    assign link.serial_out_oe = oe_ff;
    assign busy = state_ff == S_SAVE;
    assign write_permit = permit_ff;
    assign reloaded = reloaded_ff;

    // Pin edge history
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sclk_ff <= 1'b0;
            save_pin_ff <= 1'b1;
            reload_pin_ff <= 1'b1;
        end else begin
            sclk_ff <= link.shift_clock;
            save_pin_ff <= link.save_n;
            reload_pin_ff <= link.reload_n;
        end
    end

    // Protocol engine
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= S_INSTR;
            sh_ff <= '0;
            cnt_ff <= '0;
            addr_ff <= '0;
            data_ff <= '0;
            permit_ff <= 1'b0;
            reloaded_ff <= 1'b0;
            oe_ff <= 1'b0;
            out_ff <= 1'b0;
            save_cnt_ff <= '0;
        end else if (state_ff == S_SAVE) begin
            oe_ff <= 1'b0;
            sh_ff <= '0;
            save_cnt_ff <= save_cnt_ff + 32'd1;
            if (save_done) begin
                state_ff <= S_INSTR;
                permit_ff <= 1'b0;
            end
        end else if (do_save) begin
            state_ff <= S_SAVE;
            save_cnt_ff <= '0;
            sh_ff <= '0;
            oe_ff <= 1'b0;
        end else if (!link.chip_en) begin
            state_ff <= S_INSTR;
            sh_ff <= '0;
            cnt_ff <= '0;
            oe_ff <= 1'b0;
            if (do_reload) reloaded_ff <= 1'b1;
        end else begin
            if (do_reload) reloaded_ff <= 1'b1;
            unique case (state_ff)
                S_INSTR: begin
                    if (sclk_rise && (started || link.serial_in || sh_ff != '0)) begin
                        sh_ff <= shifted;
                    end
                    if (instr_done) begin
                        sh_ff <= '0;
                        addr_ff <= op_addr;
                        cnt_ff <= '0;
                        if (is_read) begin
                            state_ff <= S_RDATA;
                            data_ff <= ram_ff[op_addr];
                        end else if (opcode == OP_WRITE) begin
                            state_ff <= S_WDATA;
                        end else if (opcode == OP_WRITE_PERMIT) begin
                            permit_ff <= 1'b1;
                        end else if (opcode == OP_WRITE_DISABLE) begin
                            permit_ff <= 1'b0;
                        end
                    end
                end
                S_WDATA: begin
                    if (sclk_rise) begin
                        data_ff <= shift_word(data_ff, link.serial_in);
                        cnt_ff <= cnt_ff + 4'h1;
                        if (cnt_ff == 4'hf) state_ff <= S_INSTR;
                    end
                end
                S_RDATA: begin
                    if (sclk_fall && !oe_ff && cnt_ff == 4'h0) begin
                        oe_ff <= 1'b1;
                        out_ff <= data_ff[WORD_W-1];
                        data_ff <= shift_word(data_ff, 1'b0);
                    end else if (sclk_rise && oe_ff) begin
                        cnt_ff <= cnt_ff + 4'h1;
                        if (cnt_ff == 4'hf) begin
                            oe_ff <= 1'b0;
                            state_ff <= S_INSTR;
                        end else begin
                            out_ff <= data_ff[WORD_W-1];
                            data_ff <= shift_word(data_ff, 1'b0);
                        end
                    end
                end
                default: state_ff <= S_INSTR;
            endcase
        end
    end

    // Memory arrays
    always_ff @(posedge clk) begin
        if (do_reload) begin
            ram_ff <= nv_ff;
        end else if (wr_last && link.chip_en && may_modify) begin
            ram_ff[addr_ff] <= shift_word(data_ff, link.serial_in);
        end
        if (save_done) nv_ff <= ram_ff;
    end
endmodule : nvram_device

// >>> design/nvram_pkg.sv
// Shared constants for the serial nonvolatile RAM command port.
// Assumes a single 50 MHz system clock on both ends.
package nvram_pkg;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 4;
    localparam int DEPTH = 16;
    localparam int OP_W = 3;
    localparam int INSTR_W = 8;
    localparam logic [2:0] OP_WRITE_DISABLE = 3'h0;
    localparam logic [2:0] OP_SAVE = 3'h1;
    localparam logic [2:0] OP_WRITE = 3'h3;
    localparam logic [2:0] OP_WRITE_PERMIT = 3'h4;
    localparam logic [2:0] OP_RELOAD = 3'h5;
    localparam logic [1:0] OP_READ_HI = 2'h3;
    localparam int CLK_MHZ = 50;
    // Shift clock half period at least 400 ns
    localparam int SHIFT_HALF_NS = 400;
    localparam int SHIFT_HALF_CYC = (SHIFT_HALF_NS * CLK_MHZ + 999) / 1000;
    // Save takes at most 10 ms
    localparam int SAVE_MS = 10;
    localparam int SAVE_CYC = SAVE_MS * CLK_MHZ * 1000;
endpackage : nvram_pkg

// >>> design/nvram_link_if.sv
// Serial link between host and nonvolatile RAM port.
// Assumes both ends share clk; the wire level of the data out is resolved here.
`timescale 1ns/1ps
interface nvram_link_if;
    logic chip_en;
    logic shift_clock;
    logic serial_in;
    logic serial_out_o;
    logic serial_out_oe;
    logic serial_out;
    logic save_n;
    logic reload_n;
    assign serial_out = serial_out_oe ? serial_out_o : 1'b1;
    modport dev (input chip_en, shift_clock, serial_in, save_n, reload_n, output serial_out_o, serial_out_oe);
    modport host (output chip_en, shift_clock, serial_in, save_n, reload_n, input serial_out);
endinterface : nvram_link_if

// >>> design/nvram_host.sv
// Host end: turns one command request into a serial frame on the link.
// Assumes the device end runs on the same clk.
`timescale 1ns/1ps
module nvram_host (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Command request
    input wire logic req_valid,
    input wire logic [2:0] req_op,
    input wire logic [3:0] req_addr,
    input wire logic [15:0] req_wdata,
    output logic req_ready,
    // Read answer
    output logic rsp_valid,
    output logic [15:0] rsp_rdata,
    // Hardware pins pass-through
    input wire logic save_req_n,
    input wire logic reload_req_n,
    // Link
    nvram_link_if.host link
);
    import nvram_pkg::*;

    typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_GAP} hstate_t;

    hstate_t state_ff;
    logic [23:0] out_sh_ff;
    logic [4:0] nbits_ff;
    logic [4:0] bit_ff;
    logic [7:0] half_ff;
    logic sclk_ff;
    logic ce_ff;
    logic rd_ff;
    logic [15:0] rx_ff;
    logic rsp_ff;
    logic save_ff;
    logic reload_ff;

    wire is_rd = req_op[2:1] == OP_READ_HI;
    wire is_wr = req_op == OP_WRITE;
    wire half_done = half_ff == 8'(SHIFT_HALF_CYC - 1);
    wire last_bit = bit_ff == nbits_ff - 5'd1;

    assign req_ready = state_ff == H_IDLE;
    assign rsp_valid = rsp_ff;
    assign rsp_rdata = rx_ff;
    assign link.chip_en = ce_ff;
    assign link.shift_clock = sclk_ff;
    assign link.serial_in = out_sh_ff[23];
    assign link.save_n = save_ff;
    assign link.reload_n = reload_ff;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= H_IDLE;
            out_sh_ff <= '0;
            nbits_ff <= '0;
            bit_ff <= '0;
            half_ff <= '0;
            sclk_ff <= 1'b0;
            ce_ff <= 1'b0;
            rd_ff <= 1'b0;
            rx_ff <= '0;
            rsp_ff <= 1'b0;
            save_ff <= 1'b1;
            reload_ff <= 1'b1;
        end else begin
            rsp_ff <= 1'b0;
            save_ff <= save_req_n;
            reload_ff <= reload_req_n;
            unique case (state_ff)
                H_IDLE: begin
                    if (req_valid) begin
                        out_sh_ff <= {1'b1, req_addr, req_op, is_wr ? req_wdata : 16'h0000};
                        nbits_ff <= (is_rd || is_wr) ? 5'd24 : 5'd8;
                        rd_ff <= is_rd;
                        bit_ff <= '0;
                        half_ff <= '0;
                        ce_ff <= 1'b1;
                        state_ff <= H_SHIFT;
                    end
                end
                H_SHIFT: begin
                    half_ff <= half_done ? 8'h00 : half_ff + 8'h01;
                    if (half_done) begin
                        sclk_ff <= ~sclk_ff;
                        if (!sclk_ff) begin
                            if (rd_ff && bit_ff >= 5'd8) rx_ff <= {rx_ff[14:0], link.serial_out};
                        end else begin
                            out_sh_ff <= {out_sh_ff[22:0], 1'b0};
                            bit_ff <= bit_ff + 5'd1;
                            if (last_bit) state_ff <= H_GAP;
                        end
                    end
                end
                H_GAP: begin
                    ce_ff <= 1'b0;
                    half_ff <= half_done ? 8'h00 : half_ff + 8'h01;
                    if (half_done) begin
                        state_ff <= H_IDLE;
                        rsp_ff <= rd_ff;
                    end
                end
                default: state_ff <= H_IDLE;
            endcase
        end
    end
endmodule : nvram_host

// >>> verif/nvram_port_props.sv
// Concurrent checks on the serial link between the host and device ends.
// Assumes link signals are sampled on clk and rstn is the async active-low reset.
`timescale 1ns/1ps
module nvram_port_props (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Link
    input wire logic chip_en,
    input wire logic shift_clock,
    input wire logic serial_in,
    input wire logic serial_out_o,
    input wire logic serial_out_oe
);
    logic sclk_q_ff;
    logic [4:0] frame_rise_ff;
    logic [4:0] out_rise_ff;
    wire sclk_rise = shift_clock && !sclk_q_ff;
    // Rising shift clocks counted per frame and per output burst
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sclk_q_ff <= 1'b0;
            frame_rise_ff <= 5'h0;
            out_rise_ff <= 5'h0;
        end else begin
            sclk_q_ff <= shift_clock;
            frame_rise_ff <= !chip_en ? 5'h0 : frame_rise_ff + 5'(sclk_rise);
            out_rise_ff <= !serial_out_oe ? 5'h0 : out_rise_ff + 5'(sclk_rise);
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    a_sclk_in_frame: assert property ($rose(shift_clock) |-> chip_en)
        else $error("shift clock rose outside a frame");
    a_start_first: assert property ($rose(shift_clock) && frame_rise_ff == 5'h0 |-> serial_in)
        else $error("frame does not open with a one");
    a_frame_len: assert property ($fell(chip_en) |-> frame_rise_ff == 5'h8 || frame_rise_ff == 5'h18)
        else $error("frame length is not 8 or 24 clocks");
    a_oe_in_frame: assert property (serial_out_oe |-> chip_en || $past(chip_en))
        else $error("data out driven outside a frame");
    a_ce_release: assert property ($fell(chip_en) |=> !serial_out_oe)
        else $error("data out still driven after deselect");
    a_read_turn: assert property ($rose(serial_out_oe) |->
        frame_rise_ff == 5'h8 && $past(shift_clock, 2) && !$past(shift_clock))
        else $error("data out enabled at the wrong clock");
    a_data_moves: assert property (serial_out_oe && $past(serial_out_oe) && $changed(serial_out_o) |->
        $past(shift_clock) && !$past(shift_clock, 2))
        else $error("data out changed without a rising shift clock");
    a_word_len: assert property ($fell(serial_out_oe) && chip_en |-> out_rise_ff == 5'h10)
        else $error("read burst is not sixteen bits");
    c_read: cover property ($fell(chip_en) && frame_rise_ff == 5'h18);
    c_short: cover property ($fell(chip_en) && frame_rise_ff == 5'h8);
    c_out: cover property ($rose(serial_out_oe));
endmodule : nvram_port_props

// >>> verif/serial_nvram_command_port_bench.sv
// Bench joining host and device ends over the link, driven by host commands.
// Assumes a 50 MHz clock and a short save time set by parameter.
`timescale 1ns/1ps
module serial_nvram_command_port_bench;
    import nvram_pkg::*;
    logic clk;
    logic rstn;
    logic req_valid;
    logic req_ready;
    logic rsp_valid;
    logic save_req_n;
    logic reload_req_n;
    logic busy;
    logic write_permit;
    logic reloaded;
    logic [2:0] req_op;
    logic [3:0] req_addr;
    logic [15:0] req_wdata;
    logic [15:0] rsp_rdata;
    int n_mismatch = 0;
    int samples_checked = 0;
    nvram_link_if link ();
    nvram_device #(.SAVE_CYCLES(200)) nvram_device_inst (.clk(clk), .rstn(rstn), .link(link), .busy(busy),
        .write_permit(write_permit), .reloaded(reloaded));
    nvram_host nvram_host_inst (.clk(clk), .rstn(rstn), .req_valid(req_valid), .req_op(req_op),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .save_req_n(save_req_n), .reload_req_n(reload_req_n), .link(link));
    nvram_port_props nvram_port_props_inst (.clk(clk), .rstn(rstn), .chip_en(link.chip_en),
        .shift_clock(link.shift_clock), .serial_in(link.serial_in), .serial_out_o(link.serial_out_o),
        .serial_out_oe(link.serial_out_oe));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    function automatic logic [15:0] wd(input int i);
        return 16'h8421 ^ (16'(i) * 16'h1111);
    endfunction : wd
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wait_for(input bit want_ready, input int limit);
        int k;
        k = 0;
        while ((want_ready ? req_ready : rsp_valid) !== 1'b1 && k < limit) begin
            @(negedge clk);
            k++;
        end
        if (k >= limit) begin
            check(16'h0, 16'h1);
        end
    endtask : wait_for
    task automatic send(input logic [2:0] op, input logic [3:0] addr, input logic [15:0] data);
        @(negedge clk);
        wait_for(1'b1, 3000);
        req_valid = 1'b1;
        req_op = op;
        req_addr = addr;
        req_wdata = data;
        @(negedge clk);
        req_valid = 1'b0;
        if (op[2:1] != OP_READ_HI) begin
            wait_for(1'b1, 3000);
        end
    endtask : send
    task automatic read_word(input logic [3:0] addr, input logic [15:0] exp, input logic low);
        send({OP_READ_HI, low}, addr, 16'h0);
        wait_for(1'b0, 3000);
        check(rsp_rdata, exp);
    endtask : read_word
    task automatic pin_pulse(input bit save);
        @(negedge clk);
        save_req_n = !save;
        reload_req_n = save;
        repeat (4) @(negedge clk);
        save_req_n = 1'b1;
        reload_req_n = 1'b1;
        repeat (6) @(negedge clk);
    endtask : pin_pulse
    task automatic wait_save;
        int k;
        for (k = 0; k < 100 && busy !== 1'b1; k++) @(negedge clk);
        check(16'(busy), 16'h1);
        for (k = 0; k < 400 && busy !== 1'b0; k++) @(negedge clk);
        check(16'(write_permit), 16'h0);
    endtask : wait_save
    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        give_verdict();
    end
    initial begin
        rstn = 1'b0;
        req_valid = 1'b0;
        req_op = 3'h0;
        req_addr = 4'h0;
        req_wdata = 16'h0;
        save_req_n = 1'b1;
        reload_req_n = 1'b1;
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        check(16'(write_permit), 16'h0);
        check(16'(reloaded), 16'h0);
        send(OP_WRITE_PERMIT, 4'h9, 16'h0);
        check(16'(write_permit), 16'h1);
        pin_pulse(1'b0);
        check(16'(reloaded), 16'h1);
        for (int i = 0; i < DEPTH; i++) send(OP_WRITE, 4'(i), wd(i));
        for (int i = 0; i < DEPTH; i++) read_word(4'(i), wd(i), 1'(i));
        send(OP_WRITE_DISABLE, 4'hf, 16'h0);
        check(16'(write_permit), 16'h0);
        send(OP_WRITE, 4'h0, 16'hffff);
        read_word(4'h0, wd(0), 1'b0);
        send(OP_WRITE_PERMIT, 4'h0, 16'h0);
        send(OP_SAVE, 4'h3, 16'h0);
        wait_save();
        send(OP_WRITE_PERMIT, 4'h0, 16'h0);
        send(OP_WRITE, 4'h5, 16'h0);
        read_word(4'h5, 16'h0, 1'b1);
        send(OP_RELOAD, 4'ha, 16'h0);
        read_word(4'h5, wd(5), 1'b0);
        send(OP_WRITE_PERMIT, 4'h0, 16'h0);
        send(OP_WRITE, 4'h1, 16'hbeef);
        pin_pulse(1'b1);
        wait_save();
        send(OP_WRITE_PERMIT, 4'h0, 16'h0);
        send(OP_WRITE, 4'h1, 16'h0);
        pin_pulse(1'b0);
        read_word(4'h1, 16'hbeef, 1'b1);
        rstn = 1'b0;
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        send(OP_WRITE_PERMIT, 4'h0, 16'h0);
        send(OP_WRITE, 4'h2, 16'hffff);
        read_word(4'h2, wd(2), 1'b0);
        give_verdict();
    end
endmodule : serial_nvram_command_port_bench
